// ### psf_pkg.sv
package psf_pkg;

   localparam int unsigned CLK_HZ     = 20_000_000;
   localparam int unsigned T_PH1_MS   = 100;
   localparam int unsigned T_EARLY_MS = 4;
   localparam int unsigned PH1_CYC    = T_PH1_MS * (CLK_HZ / 1000);
   localparam int unsigned EARLY_CYC  = T_EARLY_MS * (CLK_HZ / 1000);

   // internal clocks: 2 MHz = 1/10 of clk_sys, 2.67 MHz = 2/15 of clk_sys
   localparam logic [4:0] STEP_L = 5'h01;
   localparam logic [4:0] MOD_L  = 5'h0A;
   localparam logic [4:0] STEP_H = 5'h02;
   localparam logic [4:0] MOD_H  = 5'h0F;

   localparam logic [4:0]  BIT_L    = 5'h10;
   localparam logic [4:0]  BIT_H    = 5'h0E;
   localparam logic [4:0]  NB20     = 5'h19;
   localparam logic [4:0]  NB16     = 5'h15;
   localparam logic [10:0] FRAME_L  = 11'h190;
   localparam logic [10:0] FRAME_H  = 11'h15E;
   localparam logic [10:0] FRAME_16 = 11'h126;
   localparam logic [10:0] PER_L    = 11'h258;
   localparam logic [10:0] PER_H    = 11'h215;
   localparam logic [10:0] SLOT1    = 11'h070;
   localparam logic [10:0] SLOT2    = 11'h1EA;
   localparam logic [10:0] SLOT3    = 11'h389;
   localparam logic [10:0] ASYNC_AT = 11'h001;

   localparam logic [9:0] CODE_READY  = 10'h1E7;
   localparam logic [9:0] CODE_DEFECT = 10'h1F4;
   localparam logic [1:0] P3_LAST     = 2'h1;
   localparam logic [3:0] REV13       = 4'h4;
   localparam logic [3:0] REV21       = 4'h6;
   localparam logic [7:0] NBLK22      = 8'h10;
   localparam logic [7:0] NBLK32      = 8'h26;
   localparam logic [5:0] NIB_LAST22  = 6'h16;
   localparam logic [5:0] NIB_LAST32  = 6'h20;

   // register indices; byte address is four times the index
   localparam logic [4:0] IDX_LOT0  = 5'h02;
   localparam logic [4:0] IDX_LOT1  = 5'h03;
   localparam logic [4:0] IDX_LOT2  = 5'h04;
   localparam logic [4:0] IDX_DATE0 = 5'h0C;
   localparam logic [4:0] IDX_DATE1 = 5'h0D;
   localparam logic [4:0] IDX_TYPE  = 5'h0E;
   localparam logic [4:0] IDX_PARAM = 5'h0F;
   localparam logic [4:0] IDX_SCODE = 5'h10;
   localparam logic [4:0] IDX_VCODE = 5'h11;
   localparam logic [4:0] IDX_REP   = 5'h12;
   localparam logic [4:0] IDX_MFR   = 5'h1E;
   localparam logic [5:0] IDX_NVM_LAST = 6'h1F;
   localparam logic [5:0] IDX_CTL   = 6'h20;
   localparam logic [5:0] IDX_RUN   = 6'h21;
   localparam logic [5:0] IDX_STAT  = 6'h22;

   localparam int unsigned CTL_MODE_LSB = 0;
   localparam int unsigned CTL_SLOT_LSB = 2;
   localparam int unsigned CTL_B32      = 5;
   localparam int unsigned CTL_REV21    = 6;
   localparam logic [7:0]  CTL_RST      = 8'h06;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {PH_SILENT, PH_IDENT, PH_STATUS, PH_RUN} psf_phase_e;
   typedef enum logic [1:0] {MD_ASYNC_L, MD_ASYNC_H, MD_SYNC_20, MD_SYNC_16} psf_mode_e;

   typedef struct packed {
      psf_phase_e      ph;
      logic [21:0]     p1c;
      logic [3:0]      acc;
      logic [10:0]     tc;
      logic            sent;
      logic            busy;
      logic [4:0]      bt;
      logic [4:0]      bi;
      logic [24:0]     fr;
      logic            lvl;
      logic [5:0]      nib;
      logic [1:0]      rep;
      logic            isid;
      logic [1:0]      p3c;
      logic            dfc;
      logic [2:0]      fc;
      logic            sprev;
      logic            awv;
      logic [7:0]      awa;
      logic            wv;
      logic [31:0]     wd;
      logic [3:0]      ws;
      logic            bv;
      logic [1:0]      br;
      logic            awr;
      logic            wr;
      logic            arr;
      logic            rv;
      logic [31:0]     rd;
      logic [1:0]      rr;
      logic [31:0][7:0] nvm;
      logic [7:0]      ctl;
      logic [31:0]     run;
   } psf_state_s;

endpackage

// ### psf_frame_init.sv
// Operation
// - 20-bit three-slot sync mode: slot three starts 905 fast ticks after sync.
// - 16-bit three-slot mode keeps bit period and slot start instants of 20-bit.
// - 16-bit three-slot frame lasts 294 fast ticks.
// - async low speed: 16-tick bit, 400-tick frame, 600-tick period, slow clock.
// - async high speed: 14-tick bit, 350-tick frame, 533-tick period, fast clock.
// - every power-on or undervoltage reset runs three init phases before operation.
// - first init phase sends nothing for nominally 100 ms.
// - sync pulse at least 4 ms after power-on ends the first phase early.
// - init phases two and three send the same frame in every programmed slot.
// - 20-bit init frames: value on A15..A6, low bits, counter and error zero.
// - 20-bit frame: two start, three control, error, 16 data lsb first, C2 C1 C0.
// - 16-bit init frame: start, zero error, value on A14..A5, CRC.
// - healthy device sends ready code 0x1E7 in phase three.
// - faulty device sends defect code 0x1F4 in phase three until power off or undervoltage reset.
// - supply and gain_control_loop faults are reported only in run mode.
// - phase two alternates ID and data frames, each k times, k from index 0x12.
// - block-count nibbles read 0001 0000 for 22 blocks, 0010 0110 for 32.
// - identity nibbles come from nonvolatile bytes 0x1E, 0x0E, 0x02..0x04 and others.
// - after phase three: async sends continuously, sync sends per sync pulse.
// - async mode timing comes only from the device's own clock.
// - 20-bit three-slot mode: slots one and two start at 112 and 490 ticks.
// - a sync pulse during a transmission aborts it and restarts in the slots.
`timescale 1ns/10ps
module psf_frame_init
   import psf_pkg::*;
#(
   parameter int unsigned PH1_CYCLES   = PH1_CYC,
   parameter int unsigned EARLY_CYCLES = EARLY_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        sync_pulse,
   input  wire logic        uv_reset,
   input  wire logic        diag_fault,
   input  wire logic        supply_fault,
   output logic             tx_level,
   output logic             tx_active,
   output logic [1:0]       init_phase,
   output logic             sensor_defect,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   initial begin
      if (PH1_CYCLES < 2 || PH1_CYCLES > 32'h003F_FFFF || EARLY_CYCLES >= PH1_CYCLES) begin
         $error("psf_frame_init: phase-one counts out of range");
      end
   end

   psf_state_s s;
   psf_state_s n;
   psf_mode_e  mode;
   logic       is_sync;
   logic       is16;
   logic       low;
   logic [4:0] blen;
   logic [4:0] nb_m1;
   logic [4:0] acc_sum;
   logic       tick;
   logic       sync_edge;
   logic       wrap;
   logic       cyc_ev;
   logic       start_ev;
   logic [9:0] v10;
   logic [15:0] a16;
   logic       e0;
   logic [2:0] fcv;
   logic [5:0] widx;
   logic [10:0] ftk;

   function automatic logic [10:0] slot_at(input int i);
      case (i)
         0:       slot_at = SLOT1;
         1:       slot_at = SLOT2;
         default: slot_at = SLOT3;
      endcase
   endfunction

   function automatic logic reg_ok(input logic [5:0] idx);
      reg_ok = (idx != 6'h00) && (idx <= IDX_STAT);
   endfunction

   // send order from bit 0: S1 S2, payload lsb first, then C2 C1 C0
   function automatic logic [24:0] frame_fn(input logic f16, input logic [2:0] fc,
                                            input logic err, input logic [15:0] a);
      logic [19:0] p;
      logic [2:0]  c;
      logic        fb;
      p = f16 ? {4'h0, a[14:0], err} : {a, err, fc};
      c = 3'b111;
      for (int i = 0; i < 20; i++) begin
         if (!f16 || i < 16) begin
            fb = c[2] ^ p[i];
            c  = {c[1], c[0] ^ fb, fb};
         end
      end
      frame_fn = f16 ? {4'h0, c[0], c[1], c[2], p[15:0], 2'b00}
                     : {c[0], c[1], c[2], p, 2'b00};
   endfunction

   function automatic logic [3:0] nib_fn(input psf_state_s st);
      logic       b32;
      b32 = st.ctl[CTL_B32];
      case (st.nib)
         6'h01:   nib_fn = st.ctl[CTL_REV21] ? REV21 : REV13;
         6'h02:   nib_fn = b32 ? NBLK32[7:4] : NBLK22[7:4];
         6'h03:   nib_fn = b32 ? NBLK32[3:0] : NBLK22[3:0];
         6'h04:   nib_fn = st.nvm[IDX_MFR][7:4];
         6'h05:   nib_fn = st.nvm[IDX_MFR][3:0];
         6'h06:   nib_fn = st.nvm[IDX_TYPE][7:4];
         6'h07:   nib_fn = st.nvm[IDX_TYPE][3:0];
         6'h08:   nib_fn = st.nvm[IDX_PARAM][7:4];
         6'h09:   nib_fn = st.nvm[IDX_PARAM][3:0];
         6'h0A:   nib_fn = st.nvm[IDX_SCODE][7:4];
         6'h0B:   nib_fn = st.nvm[IDX_SCODE][3:0];
         6'h0C:   nib_fn = st.nvm[IDX_VCODE][3:0];
         6'h0D:   nib_fn = st.nvm[IDX_DATE0][7:4];
         6'h0E:   nib_fn = st.nvm[IDX_DATE0][3:0];
         6'h0F:   nib_fn = st.nvm[IDX_DATE1][7:4];
         6'h10:   nib_fn = st.nvm[IDX_DATE1][3:0];
         6'h11:   nib_fn = st.nvm[IDX_LOT0][7:4];
         6'h12:   nib_fn = st.nvm[IDX_LOT0][3:0];
         6'h13:   nib_fn = st.nvm[IDX_LOT1][7:4];
         6'h14:   nib_fn = st.nvm[IDX_LOT1][3:0];
         6'h15:   nib_fn = st.nvm[IDX_LOT2][7:4];
         6'h16:   nib_fn = st.nvm[IDX_LOT2][3:0];
         default: nib_fn = 4'h0;
      endcase
   endfunction

   function automatic logic [31:0] rd_fn(input psf_state_s st, input logic [5:0] idx);
      if (idx != 6'h00 && idx <= IDX_NVM_LAST) begin
         rd_fn = {24'h000000, st.nvm[idx[4:0]]};
      end else if (idx == IDX_CTL) begin
         rd_fn = {24'h000000, st.ctl};
      end else if (idx == IDX_RUN) begin
         rd_fn = st.run;
      end else if (idx == IDX_STAT) begin
         rd_fn = {25'h0000000, st.fc, st.dfc, st.busy, st.ph};
      end else begin
         rd_fn = 32'h00000000;
      end
   endfunction

   always_comb begin
      n        = s;
      mode     = psf_mode_e'(s.ctl[CTL_MODE_LSB +: 2]);
      is_sync  = (mode == MD_SYNC_20) || (mode == MD_SYNC_16);
      is16     = (mode == MD_SYNC_16);
      low      = (mode == MD_ASYNC_L);
      blen     = low ? BIT_L : BIT_H;
      nb_m1    = is16 ? NB16 - 5'h01 : NB20 - 5'h01;
      // fractional divider: no drift, jitter of one clk_sys period per tick
      acc_sum  = {1'b0, s.acc} + (low ? STEP_L : STEP_H);
      tick     = acc_sum >= (low ? MOD_L : MOD_H);
      n.acc    = tick ? 4'(acc_sum - (low ? MOD_L : MOD_H)) : acc_sum[3:0];
      sync_edge = is_sync && sync_pulse && !s.sprev;
      n.sprev  = sync_pulse;
      // no spacing check on sync: controller keeps the minimum gap
      wrap     = !is_sync && tick && (s.tc >= (low ? PER_L : PER_H) - 11'h001);
      cyc_ev   = sync_edge || wrap;
      if (cyc_ev) begin
         n.tc = 11'h000;
      end else if (tick && s.tc != 11'h7FF) begin
         n.tc = s.tc + 11'h001;
      end

      start_ev = 1'b0;
      if (tick && s.ph != PH_SILENT) begin
         if (is_sync) begin
            for (int i = 0; i < 3; i++) begin
               if (s.ctl[CTL_SLOT_LSB + i] && n.tc == slot_at(i)) begin
                  start_ev = 1'b1;
               end
            end
         end else begin
            start_ev = (n.tc == ASYNC_AT);
         end
      end

      // sequence steps once per cycle, so every slot of an init-phase cycle carries the same word
      if (cyc_ev) begin
         n.sent = 1'b0;
         if (s.sent) begin
            case (s.ph)
               PH_IDENT: begin
                  if (s.rep == s.nvm[IDX_REP][1:0]) begin
                     n.rep  = 2'h0;
                     n.isid = !s.isid;
                     if (!s.isid) begin
                        if (s.nib == (s.ctl[CTL_B32] ? NIB_LAST32 : NIB_LAST22)) begin
                           n.ph  = PH_STATUS;
                           n.p3c = 2'h0;
                        end else begin
                           n.nib = s.nib + 6'h01;
                        end
                     end
                  end else begin
                     n.rep = s.rep + 2'h1;
                  end
               end
               PH_STATUS: begin
                  if (!s.dfc) begin
                     if (s.p3c == P3_LAST) begin
                        n.ph = PH_RUN;
                     end else begin
                        n.p3c = s.p3c + 2'h1;
                     end
                  end
               end
               default: ;
            endcase
         end
      end

      if (s.ph == PH_SILENT) begin
         if (s.p1c != 22'h3FFFFF) begin
            n.p1c = s.p1c + 22'h000001;
         end
         if (s.p1c >= 22'(PH1_CYCLES - 1) ||
             (sync_edge && s.p1c >= 22'(EARLY_CYCLES))) begin
            n.ph   = PH_IDENT;
            n.nib  = 6'h01;
            n.isid = 1'b1;
            n.rep  = 2'h0;
            n.sent = 1'b0;
         end
      end

      case (s.ph)
         PH_IDENT:  v10 = s.isid ? {4'h0, s.nib} : {6'h00, nib_fn(s)};
         PH_STATUS: v10 = s.dfc ? CODE_DEFECT : CODE_READY;
         default:   v10 = CODE_DEFECT;
      endcase
      a16 = is16 ? {1'b0, v10, 5'h00} : {v10, 6'h00};
      e0  = 1'b0;
      fcv = 3'h0;
      if (s.ph == PH_RUN) begin
         fcv = s.fc;
         if (s.dfc) begin
            a16 = is16 ? {6'h00, v10} : {v10, 6'h00};
            e0  = 1'b1;
         end else begin
            a16 = s.sent ? s.run[31:16] : s.run[15:0];
            e0  = supply_fault;
         end
      end

      if (start_ev) begin
         n.busy = 1'b1;
         n.bt   = 5'h00;
         n.bi   = 5'h00;
         n.fr   = frame_fn(is16, fcv, e0, a16);
         n.sent = 1'b1;
         if (s.ph == PH_RUN) begin
            n.fc = s.fc + 3'h1;
         end
      end else if (s.busy && tick) begin
         if (s.bt == blen - 5'h01) begin
            n.bt = 5'h00;
            if (s.bi == nb_m1) begin
               n.busy = 1'b0;
            end else begin
               n.bi = s.bi + 5'h01;
            end
         end else begin
            n.bt = s.bt + 5'h01;
         end
      end
      if (sync_edge) begin
         n.busy = 1'b0;
      end
      if (uv_reset) begin
         n.ph   = PH_SILENT;
         n.p1c  = 22'h000000;
         n.busy = 1'b0;
         n.sent = 1'b0;
         n.dfc  = 1'b0;
         n.fc   = 3'h0;
         n.tc   = 11'h000;
      end
      // set wins over the undervoltage clear so a fault in that cycle is kept
      if (diag_fault) begin
         n.dfc = 1'b1;
      end
      // manchester: a zero is low then high
      n.lvl = n.busy && ((n.bt < (blen >> 1)) ? n.fr[n.bi] : !n.fr[n.bi]);

      if (s.bv && s_axi_bready) begin
         n.bv = 1'b0;
      end
      if (s_axi_awvalid && s.awr) begin
         n.awv = 1'b1;
         n.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wr) begin
         n.wv = 1'b1;
         n.wd = s_axi_wdata;
         n.ws = s_axi_wstrb;
      end
      widx = s.awa[7:2];
      if (s.awv && s.wv && !s.bv) begin
         n.awv = 1'b0;
         n.wv  = 1'b0;
         n.bv  = 1'b1;
         n.br  = reg_ok(widx) ? RESP_OKAY : RESP_SLVERR;
         if (widx != 6'h00 && widx <= IDX_NVM_LAST && s.ws[0]) begin
            n.nvm[widx[4:0]] = s.wd[7:0];
         end
         if (widx == IDX_CTL && s.ws[0]) begin
            n.ctl = s.wd[7:0];
         end
         if (widx == IDX_RUN) begin
            for (int b = 0; b < 4; b++) begin
               if (s.ws[b]) begin
                  n.run[8*b +: 8] = s.wd[8*b +: 8];
               end
            end
         end
      end
      if (s_axi_arvalid && s.arr) begin
         n.rv = 1'b1;
         n.rd = rd_fn(s, s_axi_araddr[7:2]);
         n.rr = reg_ok(s_axi_araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s.rv && s_axi_rready) begin
         n.rv = 1'b0;
      end
      // ready is registered from the next state, so a slot frees on the same edge that the response drains
      n.awr = !n.awv && !n.bv;
      n.wr  = !n.wv && !n.bv;
      n.arr = !n.rv;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s     <= '0;
         s.ctl <= CTL_RST;
      end else begin
         s <= n;
      end
   end

   assign tx_level      = s.lvl;
   assign tx_active     = s.busy;
   assign init_phase    = s.ph;
   assign sensor_defect = s.dfc;
   assign s_axi_awready = s.awr;
   assign s_axi_wready  = s.wr;
   assign s_axi_bvalid  = s.bv;
   assign s_axi_bresp   = s.br;
   assign s_axi_arready = s.arr;
   assign s_axi_rvalid  = s.rv;
   assign s_axi_rdata   = s.rd;
   assign s_axi_rresp   = s.rr;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ftk <= 11'h000;
      end else if (start_ev) begin
         ftk <= 11'h000;
      end else if (s.busy && tick) begin
         ftk <= ftk + 11'h001;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_frame_length: assert property (
      (s.busy && tick && s.bt == blen - 5'h01 && s.bi == nb_m1 && !sync_edge && !uv_reset)
      |-> (ftk + 11'h001 == (low ? FRAME_L : (is16 ? FRAME_16 : FRAME_H))))
      else $error("frame length wrong");
   a_slot_instant: assert property (
      ($rose(s.busy) && is_sync) |-> (s.tc == SLOT1 || s.tc == SLOT2 || s.tc == SLOT3))
      else $error("frame outside slot start");
   a_async_start: assert property (
      ($rose(s.busy) && !is_sync) |-> (s.tc == ASYNC_AT && $past(s.tc) == 11'h000))
      else $error("async frame off period");
   a_silent_phase: assert property (
      (s.ph == PH_SILENT) |-> (!s.busy && !s.lvl))
      else $error("transmission in phase one");
   a_early_exit: assert property (
      (s.ph == PH_IDENT && $past(s.ph) == PH_SILENT)
      |-> ($past(s.p1c) >= 22'(EARLY_CYCLES)))
      else $error("phase one ended too soon");
   a_init_layout: assert property (
      ($rose(s.busy) && s.ph == PH_IDENT && !is16) |-> (s.fr[11:0] == 12'h000))
      else $error("init frame low bits not zero");
   a_ready_code: assert property (
      ($rose(s.busy) && s.ph == PH_STATUS && !s.dfc && !is16)
      |-> (s.fr[21:12] == CODE_READY))
      else $error("ready code wrong");
   a_defect_hold: assert property (
      (s.ph == PH_STATUS && s.dfc && !uv_reset) |=> (s.ph == PH_STATUS && s.dfc))
      else $error("defect state left");
   a_sync_abort: assert property (
      (sync_edge && s.busy) |=> (!s.busy && s.tc == 11'h000))
      else $error("sync did not abort frame");
   a_uv_restart: assert property (
      uv_reset |=> (s.ph == PH_SILENT && s.p1c == 22'h000000 && !s.busy))
      else $error("undervoltage did not restart");

endmodule // psf_frame_init

// ### psf_ecu_model.sv
`timescale 1ns/10ps
// controller side: decodes the loop current and sends sync pulses on request
module psf_ecu_model (
   input  wire logic clk_sys,
   input  wire logic tx_active,
   input  wire logic tx_level,
   input  wire logic fire,
   output logic      sync_pulse
);
   int unsigned cyc     = 0;
   int unsigned t0      = 0;
   int unsigned t_sync  = 0;
   int unsigned bit_cyc = 105;
   int unsigned q_rise[$];
   int unsigned q_dur[$];
   logic [24:0] q_bits[$];
   logic [24:0] sh;
   logic        act_d   = 1'h0;

   initial sync_pulse = 1'h0;
   // pulse spacing is left to the bench
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      sync_pulse <= fire;
      act_d <= tx_active;
      if (fire && !sync_pulse) t_sync <= cyc;
      if (tx_active && !act_d) begin
         t0 <= cyc;
         q_rise.push_back(cyc - t_sync);
      end
      if (!tx_active && act_d) q_dur.push_back(cyc - t0);
      // sample late in the bit: second half high means a zero
      if (tx_active && act_d && (cyc - t0) % bit_cyc == bit_cyc * 3 / 4) begin
         sh[(cyc - t0) / bit_cyc] = ~tx_level;
         if ((cyc - t0) / bit_cyc == 24) q_bits.push_back(sh);
      end
   end
endmodule // psf_ecu_model

// ### test_psf_frame_init.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_psf_frame_init
   import psf_pkg::*;
;
   logic        clk_sys = 1'h0, rst_n = 1'h0, fire = 1'h0;
   logic        uv_reset = 1'h0, diag_fault = 1'h0, supply_fault = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, init_phase;
   logic        sync_pulse, tx_level, tx_active, sensor_defect;
   int          error_cnt = 0, checked = 0, n;

   psf_frame_init #(.PH1_CYCLES(4000), .EARLY_CYCLES(20)) dut_u (.*);
   psf_ecu_model ecu_u (.clk_sys(clk_sys), .tx_active(tx_active), .tx_level(tx_level),
      .fire(fire), .sync_pulse(sync_pulse));

   always #25 clk_sys = ~clk_sys;

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      if (n == 50) begin error_cnt++; conclude(); end
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (n == 50) begin error_cnt++; conclude(); end
      @(posedge clk_sys);
   endtask

   task automatic sync_gap(input int gap);
      fire <= 1'h1;
      repeat (2) @(posedge clk_sys);
      fire <= 1'h0;
      repeat (gap - 2) @(posedge clk_sys);
   endtask

   task automatic clear();
      ecu_u.q_rise.delete();
      ecu_u.q_dur.delete();
      ecu_u.q_bits.delete();
   endtask

   // expected 20-bit frame in send order, bit 0 first on the line
   function automatic logic [24:0] frame20(input logic [15:0] a);
      logic [2:0]  c;
      logic [21:0] p;
      c = 3'h7;
      p = {a, 6'h00};
      for (int i = 2; i < 22; i++) c = {c[1], c[0] ^ c[2] ^ p[i], c[2] ^ p[i]};
      return {c[0], c[1], c[2], p};
   endfunction

   // tick phase against clk_sys leaves a few cycles of slack
   function automatic logic near(input int unsigned g, input int unsigned e);
      return g + 6 >= e && g <= e + 6;
   endfunction

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int unsigned k;
      int unsigned slot_t[3];
      int unsigned md[2][3];
      k = $urandom(68) % 4 + 1;
      slot_t = '{112, 490, 905};
      md = '{'{160, 4000, 6000}, '{105, 2625, 3997}};
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (2) @(posedge clk_sys);
      rd({IDX_CTL, 2'h0}, d, r);
      `CHK("ctl_rst", {24'h0, CTL_RST}, d)
      sync_gap(4);
      `CHK("early_sync", 2'h0, init_phase)
      wr({1'h0, IDX_REP, 2'h0}, k - 1);
      wr({IDX_CTL, 2'h0}, 32'h1E);
      rd(8'hFC, d, r);
      `CHK("unmapped", RESP_SLVERR, r)
      supply_fault <= 1'h1;
      repeat (k + 2) sync_gap(9600);
      `CHK("phase", 2'h1, init_phase)
      for (int i = 0; i < 3 * k + 3; i++) begin
         `CHK("frame", frame20(i < 3 * k ? 16'h0040 : 16'h0100), ecu_u.q_bits[i])
         `CHK("slot", 1'h1, near(ecu_u.q_rise[i], slot_t[i % 3] * 15 / 2))
      end
      $display("test sync20 done");
      wr({IDX_CTL, 2'h0}, 32'h1F);
      clear();
      sync_gap(9600);
      sync_gap(5000);
      sync_gap(9600);
      for (int i = 0; i < 8; i++) begin
         `CHK("slot16", 1'h1, near(ecu_u.q_rise[i], slot_t[i < 3 ? i : i < 5 ? i - 3 : i - 5] * 15 / 2))
         `CHK("len16", i != 4, near(ecu_u.q_dur[i], 2205))
      end
      `CHK("n16", 8, ecu_u.q_rise.size())
      $display("test sync16 done");
      wr({IDX_CTL, 2'h0}, 32'h04);
      diag_fault <= 1'h1;
      @(posedge clk_sys);
      diag_fault <= 1'h0;
      repeat (3) @(posedge clk_sys);
      `CHK("defect", 1'h1, sensor_defect)
      uv_reset <= 1'h1;
      @(posedge clk_sys);
      uv_reset <= 1'h0;
      clear();
      repeat (3) @(posedge clk_sys);
      `CHK("uv_phase", 2'h0, init_phase)
      `CHK("uv_def", 1'h0, sensor_defect)
      repeat (3950) @(posedge clk_sys);
      `CHK("silent", 0, ecu_u.q_rise.size())
      `CHK("ph1", 2'h0, init_phase)
      repeat (100) @(posedge clk_sys);
      `CHK("ph1_end", 2'h1, init_phase)
      $display("test reset done");
      for (int m = 0; m < 2; m++) begin
         // mode change only between frames, else bit length shifts mid-frame
         for (n = 0; n < 8000 && tx_active; n++) @(posedge clk_sys);
         if (n == 8000) begin error_cnt++; conclude(); end
         wr({IDX_CTL, 2'h0}, 32'h04 + m);
         ecu_u.bit_cyc = md[m][0];
         for (n = 0; n < 8000 && tx_active; n++) @(posedge clk_sys);
         if (n == 8000) begin error_cnt++; conclude(); end
         clear();
         repeat (2 * md[m][2] + 100) @(posedge clk_sys);
         `CHK("period", 1'h1, near(ecu_u.q_rise[1] - ecu_u.q_rise[0], md[m][2]))
         `CHK("flen", 1'h1, near(ecu_u.q_dur[0], md[m][1]))
         `CHK("crc", frame20(ecu_u.q_bits[0][21:6]), ecu_u.q_bits[0])
         $display("test async %0d done", m);
      end
      conclude();
   end
endmodule // test_psf_frame_init
